// ---- brt_pkg.sv ----
package brt_pkg;

   // ------------------------------------------------------------
   // Array geometry
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W = 11;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned MEM_DEPTH = 2048;
   localparam int unsigned CLK_BYTES = 8;
   localparam int unsigned TIME_BYTES = 7;
   localparam logic [10:0] CLOCK_CTRL_ADDR = 11'h7f8;

   // ------------------------------------------------------------
   // Access timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned ADDR_ACCESS_NS = 70;
   localparam int unsigned SEL_ACCESS_NS = 70;
   localparam int unsigned GATE_ACCESS_NS = 35;
   localparam int unsigned OUT_HOLD_NS = 10;
   localparam int unsigned CNT_W = 5;
   // Longest delays round down, least hold rounds up
   localparam logic [4:0] ADDR_ACCESS_CYC = 5'(ADDR_ACCESS_NS / CLK_PERIOD_NS);
   localparam logic [4:0] SEL_ACCESS_CYC = 5'(SEL_ACCESS_NS / CLK_PERIOD_NS);
   localparam logic [4:0] GATE_ACCESS_CYC = 5'(GATE_ACCESS_NS / CLK_PERIOD_NS);
   localparam logic [4:0] OUT_HOLD_CYC =
      5'((OUT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int unsigned SECOND_NS = 1_000_000_000;
   localparam int unsigned SEC_CYCLES_DEFAULT = SECOND_NS / CLK_PERIOD_NS;
   localparam int unsigned PRESC_W = 28;

   // ------------------------------------------------------------
   // Clock bytes and control register
   // ------------------------------------------------------------
   localparam int unsigned T_SEC = 0;
   localparam int unsigned T_MIN = 1;
   localparam int unsigned T_HOUR = 2;
   localparam int unsigned T_DAY = 3;
   localparam int unsigned T_DATE = 4;
   localparam int unsigned T_MONTH = 5;
   localparam int unsigned T_YEAR = 6;
   localparam logic [6:0][7:0] TIME_RESET = {8'h00, 8'h01, 8'h01, 8'h01,
                                             8'h00, 8'h00, 8'h00};
   localparam logic [6:0][7:0] TIME_LOW = {8'h00, 8'h01, 8'h01, 8'h01,
                                           8'h00, 8'h00, 8'h00};
   localparam logic [6:0][7:0] TIME_HIGH = {8'h99, 8'h12, 8'h31, 8'h07,
                                            8'h23, 8'h59, 8'h59};
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int unsigned CTRL_SET_BIT = 7;
   localparam int unsigned CTRL_HOLD_BIT = 6;
   localparam logic [7:0] UNDEF_FILL = 8'h00;

endpackage : brt_pkg

// ---- brt_time_if.sv ----
`timescale 1ns/1ps
interface brt_time_if;
   logic tick;
   logic load;
   logic [6:0][7:0] now;
   logic [6:0][7:0] set_val;
   modport core (output tick, output now, input load, input set_val);
   modport host (input tick, input now, output load, output set_val);
endinterface : brt_time_if

// ---- brt_clock_core.sv ----
`timescale 1ns/1ps
module brt_clock_core #(
   parameter int unsigned SEC_CYCLES = brt_pkg::SEC_CYCLES_DEFAULT
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   brt_time_if.core tif
);

   logic [brt_pkg::PRESC_W-1:0] presc_reg;
   logic [brt_pkg::PRESC_W-1:0] presc_next;
   logic [6:0][7:0] tm_reg;
   logic [6:0][7:0] tm_next;
   logic tick;

   // ------------------------------------------------------------
   // Calendar decoding
   // ------------------------------------------------------------
   function automatic logic leap_year(input logic [7:0] yr);
      // BCD year divisible by four
      leap_year = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                        : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
   endfunction : leap_year

   function automatic logic [7:0] field_high(input int unsigned i,
                                             input logic [6:0][7:0] t);
      field_high = brt_pkg::TIME_HIGH[i];
      if (i == brt_pkg::T_DATE) begin
         unique case (t[brt_pkg::T_MONTH])
            8'h02: field_high = leap_year(t[brt_pkg::T_YEAR]) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: field_high = 8'h30;
            default: field_high = 8'h31;
         endcase
      end
   endfunction : field_high

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      bcd_inc = (v[3:0] >= 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
   endfunction : bcd_inc

   // ------------------------------------------------------------
   // Second prescaler
   // ------------------------------------------------------------
   assign tick = (presc_reg == brt_pkg::PRESC_W'(SEC_CYCLES - 1));
   assign presc_next = tick ? '0 : presc_reg + 1'b1;

   always_comb begin
      logic carry;
      carry = 1'b1;
      tm_next = tm_reg;
      if (tif.load) begin
         tm_next = tif.set_val;
      end else if (tick) begin
         for (int unsigned i = 0; i < brt_pkg::TIME_BYTES; i++) begin
            if (carry) begin
               if (tm_reg[i] >= field_high(i, tm_reg)) begin
                  tm_next[i] = brt_pkg::TIME_LOW[i];
               end else begin
                  tm_next[i] = bcd_inc(tm_reg[i]);
                  // Weekday steps beside the date, never carries
                  carry = (i == brt_pkg::T_DAY);
               end
            end
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         presc_reg <= '0;
         tm_reg <= brt_pkg::TIME_RESET;
      end else if (clk_en) begin
         presc_reg <= presc_next;
         tm_reg <= tm_next;
      end
   end

   assign tif.tick = tick;
   assign tif.now = tm_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_hour_range: assert property (tm_reg[brt_pkg::T_HOUR] <= 8'h23)
      else $error("hour counter left 24-hour range");
   a_leap_feb: assert property (
      (clk_en && tick && !tif.load && tm_reg[2:0] == 24'h235959
       && tm_reg[brt_pkg::T_MONTH] == 8'h02 && tm_reg[brt_pkg::T_DATE] == 8'h28)
      |=> tm_reg[brt_pkg::T_DATE] == (leap_year(tm_reg[brt_pkg::T_YEAR]) ? 8'h29 : 8'h01))
      else $error("february rollover wrong");

endmodule : brt_clock_core

// ---- brt_sram_top.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Eleven address bits pick one byte of 2048; each access moves eight bits.
// - Top eight bytes hold control and time, readable and writable as memory.
// - Time and calendar are BCD, hours run 00 to 23.
// - Dates roll for 28, 29, 30, 31 day months; leap every fourth year.
// - Byte 0x7f8 controls clock byte access.
// - Clock bytes are separate cells, refreshed from counters once per second.
// - Select low with write strobe high reads the addressed byte.
// - Data pins driven only with select and gate low, strobe high.
// - Read data valid after latest of address, select and gate delays.
// - Pins carry undefined filler until the latest of the address, select and gate delays expires.
// - On address change old data held for hold time, then undefined.
// - Power fail blocks every write to array and clock bytes.
// - Below switchover the battery runs; data and counters are kept.
// - Select and strobe both low writes pin data, gate ignored.
// - Write spans later falling to earlier rising edge; address held.
// - Low battery at start blocks the first write, then clears.
// - During power fail data pins float and select, gate and strobe are ignored; below_switchover still sets battery_mode.
module brt_sram_top #(
   parameter int unsigned SEC_CYCLES = brt_pkg::SEC_CYCLES_DEFAULT
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic chip_sel_n,
   input wire logic out_gate_n,
   input wire logic write_n,
   input wire logic [10:0] byte_addr,
   input wire logic [7:0] data_pins_in,
   output logic [7:0] data_pins_out,
   output logic data_pins_oe_n,
   output logic data_valid,
   input wire logic power_fail,
   input wire logic below_switchover,
   input wire logic battery_low_det,
   output logic battery_mode,
   output logic battery_low_flag_n
);

   brt_time_if tif ();

   brt_clock_core #(
      .SEC_CYCLES(SEC_CYCLES)
   ) u_core (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .tif(tif)
   );

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   localparam int unsigned ARRAY_DEPTH = brt_pkg::MEM_DEPTH - brt_pkg::CLK_BYTES;
   logic [7:0] mem [0:ARRAY_DEPTH-1];
   logic [7:0] cbyte_reg [brt_pkg::CLK_BYTES];

   function automatic logic is_clk_addr(input logic [10:0] a);
      is_clk_addr = (a >= brt_pkg::CLOCK_CTRL_ADDR);
   endfunction : is_clk_addr

   function automatic logic [4:0] sat_inc(input logic [4:0] v);
      sat_inc = (v == 5'h1f) ? v : v + 5'h01;
   endfunction : sat_inc

   // ------------------------------------------------------------
   // Host port decode
   // ------------------------------------------------------------
   logic [10:0] addr_q_reg;
   logic [4:0] addr_cnt_reg;
   logic [4:0] sel_cnt_reg;
   logic [4:0] gate_cnt_reg;
   logic [4:0] addr_cnt_next;
   logic [4:0] sel_cnt_next;
   logic [4:0] gate_cnt_next;
   logic keep_reg;
   logic keep_next;
   logic [7:0] out_next;
   logic [7:0] rd_data;
   wire rd_drive;
   wire wr_act;
   wire addr_chg;
   wire acc_ok;
   wire hold_win;

   assign rd_drive = !chip_sel_n && !out_gate_n && write_n && !power_fail;
   // Write when select and strobe low
   assign wr_act = !chip_sel_n && !write_n && !power_fail;
   assign addr_chg = (byte_addr != addr_q_reg);

   assign addr_cnt_next = addr_chg ? 5'h00 : sat_inc(addr_cnt_reg);
   assign sel_cnt_next = (chip_sel_n || power_fail) ? 5'h00 : sat_inc(sel_cnt_reg);
   assign gate_cnt_next = (out_gate_n || power_fail) ? 5'h00 : sat_inc(gate_cnt_reg);

   assign acc_ok = !addr_chg
                   && addr_cnt_reg >= brt_pkg::ADDR_ACCESS_CYC
                   && sel_cnt_reg >= brt_pkg::SEL_ACCESS_CYC
                   && gate_cnt_reg >= brt_pkg::GATE_ACCESS_CYC;

   // Top eight bytes map to clock cells
   assign rd_data = is_clk_addr(byte_addr) ? cbyte_reg[byte_addr[2:0]]
                                           : mem[byte_addr];

   // Old data held after address change
   assign hold_win = addr_chg ? data_valid : keep_reg;
   assign keep_next = rd_drive && hold_win
                      && (addr_chg || addr_cnt_reg < brt_pkg::OUT_HOLD_CYC - 5'h01);
   assign out_next = acc_ok ? rd_data : (hold_win ? data_pins_out : brt_pkg::UNDEF_FILL);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         addr_q_reg <= '0;
         addr_cnt_reg <= '0;
         sel_cnt_reg <= '0;
         gate_cnt_reg <= '0;
         keep_reg <= 1'b0;
         data_pins_out <= brt_pkg::UNDEF_FILL;
         data_pins_oe_n <= 1'b1;
         data_valid <= 1'b0;
      end else if (clk_en) begin
         addr_q_reg <= byte_addr;
         addr_cnt_reg <= addr_cnt_next;
         sel_cnt_reg <= sel_cnt_next;
         gate_cnt_reg <= gate_cnt_next;
         keep_reg <= keep_next;
         data_pins_out <= out_next;
         data_pins_oe_n <= !rd_drive;
         data_valid <= rd_drive && acc_ok;
      end
   end

   // ------------------------------------------------------------
   // Write path
   // ------------------------------------------------------------
   logic wr_active_reg;
   logic [10:0] wr_addr_reg;
   logic [7:0] wr_data_reg;
   logic bok_armed_reg;
   logic bok_flag_reg;
   logic load_reg;
   logic upd_tick_reg;
   wire cb_free;
   wire wr_end;
   wire mem_we;
   wire clk_we;
   wire ctrl_we;
   wire upd;

   assign wr_end = wr_active_reg && !wr_act;
   assign mem_we = wr_end && !power_fail && !bok_flag_reg;
   assign clk_we = mem_we && is_clk_addr(wr_addr_reg);
   assign ctrl_we = clk_we && wr_addr_reg[2:0] == 3'h0;
   assign cb_free = !cbyte_reg[0][brt_pkg::CTRL_HOLD_BIT]
                    && !cbyte_reg[0][brt_pkg::CTRL_SET_BIT];
   // Copy stepped counters, one edge late
   assign upd = upd_tick_reg && cb_free;

   always_ff @(posedge clk) begin
      if (clk_en && mem_we && !is_clk_addr(wr_addr_reg)) begin
         mem[wr_addr_reg] <= wr_data_reg;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_active_reg <= 1'b0;
         wr_addr_reg <= '0;
         wr_data_reg <= '0;
         load_reg <= 1'b0;
         upd_tick_reg <= 1'b0;
      end else if (clk_en) begin
         wr_active_reg <= wr_act;
         upd_tick_reg <= tif.tick && cb_free;
         if (wr_act) begin
            wr_addr_reg <= byte_addr;
            wr_data_reg <= data_pins_in;
         end
         load_reg <= ctrl_we && cbyte_reg[0][brt_pkg::CTRL_SET_BIT]
                     && !wr_data_reg[brt_pkg::CTRL_SET_BIT];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bok_armed_reg <= 1'b0;
         bok_flag_reg <= 1'b0;
         battery_low_flag_n <= 1'b1;
         battery_mode <= 1'b0;
      end else if (clk_en) begin
         bok_armed_reg <= 1'b1;
         if (!bok_armed_reg) begin
            bok_flag_reg <= battery_low_det;
            battery_low_flag_n <= !battery_low_det;
         end else if (wr_end && !power_fail) begin
            bok_flag_reg <= 1'b0;
            battery_low_flag_n <= 1'b1;
         end
         battery_mode <= below_switchover;
      end
   end

   // ------------------------------------------------------------
   // Clock bytes
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cbyte_reg[0] <= brt_pkg::CTRL_RESET;
      end else if (clk_en && ctrl_we) begin
         cbyte_reg[0] <= wr_data_reg;
      end
   end

   for (genvar i = 1; i < brt_pkg::CLK_BYTES; i++) begin : g_cbyte
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            cbyte_reg[i] <= brt_pkg::TIME_RESET[i-1];
         end else if (clk_en) begin
            if (clk_we && wr_addr_reg[2:0] == 3'(i)) begin
               cbyte_reg[i] <= wr_data_reg;
            end else if (upd) begin
               cbyte_reg[i] <= tif.now[i-1];
            end
         end
      end
      assign tif.set_val[i-1] = cbyte_reg[i];
   end

   assign tif.load = load_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_drive_window: assert property (
      (!data_pins_oe_n && $past(clk_en)) |-> $past(rd_drive))
      else $error("data pins driven outside read window");
   a_read_enable: assert property (
      (clk_en && rd_drive) |=> !data_pins_oe_n)
      else $error("read did not enable pins");
   a_access_wait: assert property (
      (data_valid && $past(clk_en))
      |-> $past(addr_cnt_reg) >= 5'd14 && $past(sel_cnt_reg) >= 5'd14
          && $past(gate_cnt_reg) >= 5'd7)
      else $error("data valid before access delays");
   a_undef_fill: assert property (
      (clk_en && rd_drive && !acc_ok && !hold_win)
      |=> data_pins_out == brt_pkg::UNDEF_FILL && !data_valid)
      else $error("filler not shown before access");
   a_hold_old: assert property (
      (clk_en && rd_drive && addr_chg && data_valid) |=> $stable(data_pins_out))
      else $error("old data not held on address change");
   a_pf_nowrite: assert property (power_fail |-> !mem_we)
      else $error("write under power fail");
   a_pf_float: assert property (
      (clk_en && power_fail) |=> data_pins_oe_n && !data_valid)
      else $error("pins driven in power fail");
   a_write_span: assert property (
      mem_we |-> wr_active_reg && !wr_act && $past(wr_act))
      else $error("write committed outside strobe window");
   a_bok_first: assert property (
      (clk_en && bok_armed_reg && bok_flag_reg && wr_end && !power_fail)
      |-> !mem_we ##1 !bok_flag_reg && battery_low_flag_n)
      else $error("low battery flag did not block one write");
   a_sec_copy: assert property (
      (clk_en && upd && !clk_we) |=> cbyte_reg[1] == $past(tif.now[0]))
      else $error("seconds byte not refreshed");
   a_set_freeze: assert property (
      (clk_en && cbyte_reg[0][brt_pkg::CTRL_SET_BIT] && !clk_we)
      |=> $stable(cbyte_reg[7]))
      else $error("year byte changed while set bit high");

   // ------------------------------------------------------------
   // Write, access and battery mode checks
   // ------------------------------------------------------------
   a_clk_write: assert property (
      (clk_en && clk_we) |=> cbyte_reg[$past(wr_addr_reg[2:0])] == $past(wr_data_reg))
      else $error("clock byte write lost");
   a_mem_write: assert property (
      (clk_en && mem_we && !is_clk_addr(wr_addr_reg)) |=> mem[$past(wr_addr_reg)] == $past(wr_data_reg))
      else $error("array byte write lost");
   a_wr_capture: assert property (
      (clk_en && !chip_sel_n && !write_n && !power_fail)
      |=> wr_active_reg && wr_addr_reg == $past(byte_addr) && wr_data_reg == $past(data_pins_in))
      else $error("write cycle not captured");
   a_batt_mode: assert property (clk_en |=> battery_mode == $past(below_switchover))
      else $error("battery mode does not follow switchover");
   a_count_clear: assert property ((clk_en && chip_sel_n) |=> sel_cnt_reg == 5'h00)
      else $error("select counter not cleared");
   a_oe_release: assert property ((clk_en && !rd_drive) |=> data_pins_oe_n)
      else $error("pins still driven after read ended");
   a_valid_data: assert property (
      (clk_en && rd_drive && acc_ok) |=> data_valid && data_pins_out == $past(rd_data))
      else $error("valid read data not shown");

endmodule : brt_sram_top

// ---- brt_host_model.sv ----
`timescale 1ns/1ps
module brt_host_model (
   input wire logic clk,
   input wire logic [7:0] data_pins_out,
   input wire logic data_pins_oe_n,
   input wire logic data_valid,
   output logic chip_sel_n,
   output logic out_gate_n,
   output logic write_n,
   output logic [10:0] byte_addr,
   output logic [7:0] data_pins_in
);
   logic host_drv = 1'b0;
   logic [7:0] host_val = 8'h00;
   logic [7:0] last_q = 8'h00;
   int bad = 0;

   initial begin
      chip_sel_n = 1'b1;
      out_gate_n = 1'b1;
      write_n = 1'b1;
      byte_addr = 11'h000;
   end

   // Released wire shows inverse of last level
   assign data_pins_in = host_drv ? host_val : (!data_pins_oe_n ? data_pins_out : ~last_q);
   always @(posedge clk) last_q <= data_pins_in;

   // ------------------------------------------------------------
   // Bus cycles
   // ------------------------------------------------------------
   // Address held through write
   task automatic write_byte(input logic [10:0] a, input logic [7:0] d,
                             input logic by_sel, input logic g);
      @(negedge clk);
      byte_addr = a;
      host_val = d;
      host_drv = 1'b1;
      out_gate_n = g;
      chip_sel_n = 1'b0;
      write_n = 1'b0;
      repeat (10) begin
         @(negedge clk);
         if (data_pins_oe_n === 1'b0) bad++;
      end
      if (by_sel) chip_sel_n = 1'b1;
      else write_n = 1'b1;
      @(negedge clk);
      chip_sel_n = 1'b1;
      write_n = 1'b1;
      out_gate_n = 1'b1;
      host_drv = 1'b0;
   endtask : write_byte

   task automatic read_byte(input logic [10:0] a, input int gap,
                            output logic [7:0] d, output int cyc);
      @(negedge clk);
      byte_addr = a;
      chip_sel_n = 1'b0;
      write_n = 1'b1;
      repeat (gap) begin
         @(negedge clk);
         if (data_pins_oe_n === 1'b0) bad++;
      end
      out_gate_n = 1'b0;
      cyc = 0;
      while (data_valid !== 1'b1 && cyc < 40) begin
         @(posedge clk);
         #1;
         cyc++;
         if (!data_pins_oe_n && !data_valid && data_pins_out !== brt_pkg::UNDEF_FILL) bad++;
      end
      d = data_pins_in;
   endtask : read_byte

   task automatic move_addr(input logic [10:0] a, output logic [7:0] h1,
                            output logic [7:0] h2);
      int n;
      @(negedge clk);
      byte_addr = a;
      @(posedge clk);
      #1;
      h1 = data_pins_out;
      @(posedge clk);
      #1;
      h2 = data_pins_out;
      // After the hold, filler with valid low
      n = 0;
      while (data_pins_out !== brt_pkg::UNDEF_FILL && n < 10) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 10 || data_valid !== 1'b0) bad++;
   endtask : move_addr

   task automatic idle();
      @(negedge clk);
      chip_sel_n = 1'b1;
      out_gate_n = 1'b1;
   endtask : idle
endmodule : brt_host_model

// ---- brt_sram_top_tb.sv ----
`timescale 1ns/1ps
module brt_sram_top_tb;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic clk_en = 1'b1;
   logic power_fail = 1'b0;
   logic below_switchover = 1'b0;
   logic battery_low_det = 1'b1;
   logic chip_sel_n, out_gate_n, write_n;
   logic [10:0] byte_addr;
   logic [7:0] data_pins_in, data_pins_out, rd, h1, h2;
   logic data_pins_oe_n, data_valid, battery_mode, battery_low_flag_n;
   int n_mismatch = 0;
   int checked = 0;
   int cyc;
   localparam logic [4:0][10:0] A_TAB = {11'h2aa, 11'h7f7, 11'h401, 11'h001, 11'h000};
   localparam logic [4:0][7:0] D_TAB = {8'h69, 8'h96, 8'hc3, 8'h3c, 8'h81};
   // Set values, year down to seconds
   localparam logic [3:0][6:0][7:0] SET_TAB = {
      {8'h99, 8'h12, 8'h31, 8'h05, 8'h23, 8'h59, 8'h59},
      {8'h99, 8'h04, 8'h30, 8'h03, 8'h23, 8'h59, 8'h59},
      {8'h04, 8'h02, 8'h28, 8'h01, 8'h23, 8'h59, 8'h59},
      {8'h01, 8'h02, 8'h28, 8'h07, 8'h23, 8'h59, 8'h59}};
   localparam logic [3:0][5:0][7:0] EXP_TAB = {
      {8'h00, 8'h01, 8'h01, 8'h06, 8'h00, 8'h00},
      {8'h99, 8'h05, 8'h01, 8'h04, 8'h00, 8'h00},
      {8'h04, 8'h02, 8'h29, 8'h02, 8'h00, 8'h00},
      {8'h01, 8'h03, 8'h01, 8'h01, 8'h00, 8'h00}};

   initial begin
      forever #2.5 clk = ~clk;
   end

   brt_sram_top #(.SEC_CYCLES(20)) dut (
      .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .chip_sel_n(chip_sel_n),
      .out_gate_n(out_gate_n), .write_n(write_n), .byte_addr(byte_addr),
      .data_pins_in(data_pins_in), .data_pins_out(data_pins_out),
      .data_pins_oe_n(data_pins_oe_n), .data_valid(data_valid),
      .power_fail(power_fail), .below_switchover(below_switchover),
      .battery_low_det(battery_low_det), .battery_mode(battery_mode),
      .battery_low_flag_n(battery_low_flag_n));

   brt_host_model host (
      .clk(clk), .data_pins_out(data_pins_out), .data_pins_oe_n(data_pins_oe_n),
      .data_valid(data_valid), .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n),
      .write_n(write_n), .byte_addr(byte_addr), .data_pins_in(data_pins_in));

   // ------------------------------------------------------------
   // Checking and verdict
   // ------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : print_verdict

   initial begin
      #100000;
      n_mismatch++;
      print_verdict();
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (4) @(negedge clk);
      check(8'(battery_low_flag_n), 8'h01);
      check(8'(data_pins_oe_n), 8'h01);
      reset_n = 1'b1;
      @(posedge clk);
      #1;
      check(8'(battery_low_flag_n), 8'h00);
      host.write_byte(11'h124, 8'ha5, 1'b0, 1'b1);
      @(posedge clk);
      #1;
      check(8'(battery_low_flag_n), 8'h01);
      for (int i = 0; i < 5; i++) host.write_byte(A_TAB[i], D_TAB[i], i[0], i[1]);
      for (int i = 0; i < 5; i++) begin
         host.read_byte(A_TAB[i], 0, rd, cyc);
         host.idle();
         check(rd, D_TAB[i]);
         check(8'(cyc >= 14 && cyc <= 17), 8'h01);
      end
      host.read_byte(11'h124, 0, rd, cyc);
      host.idle();
      check(8'(rd === 8'ha5), 8'h00);
      host.read_byte(A_TAB[3], 20, rd, cyc);
      check(rd, D_TAB[3]);
      check(8'(cyc >= 7 && cyc <= 10), 8'h01);
      host.move_addr(A_TAB[0], h1, h2);
      check(h1, D_TAB[3]);
      check(h2, D_TAB[3]);
      host.read_byte(A_TAB[0], 0, rd, cyc);
      host.idle();
      check(rd, D_TAB[0]);
      check(8'(host.bad), 8'h00);
      @(negedge clk);
      power_fail = 1'b1;
      below_switchover = 1'b1;
      host.write_byte(A_TAB[1], 8'hee, 1'b0, 1'b1);
      host.read_byte(A_TAB[1], 0, rd, cyc);
      check(8'(data_pins_oe_n), 8'h01);
      check(8'(battery_mode), 8'h01);
      host.idle();
      power_fail = 1'b0;
      below_switchover = 1'b0;
      host.read_byte(A_TAB[1], 0, rd, cyc);
      host.idle();
      check(rd, D_TAB[1]);
      check(8'(battery_mode), 8'h00);
      for (int c = 0; c < 4; c++) begin
         host.write_byte(11'h7f8, 8'h80, 1'b1, 1'b1);
         for (int i = 0; i < 7; i++) host.write_byte(11'h7f9 + 11'(i), SET_TAB[c][i], 1'b1, 1'b1);
         host.write_byte(11'h7f8, 8'h00, 1'b1, 1'b1);
         repeat (30) @(negedge clk);
         host.write_byte(11'h7f8, 8'h40, 1'b1, 1'b1);
         for (int i = 0; i < 6; i++) begin
            host.read_byte(11'h7fa + 11'(i), 0, rd, cyc);
            host.idle();
            check(rd, EXP_TAB[c][i]);
         end
         host.read_byte(11'h7f9, 0, rd, cyc);
         host.idle();
         check(8'(rd >= 8'h01 && rd <= 8'h03), 8'h01);
         host.read_byte(11'h7f8, 0, rd, cyc);
         host.idle();
         check(rd, 8'h40);
      end
      print_verdict();
   end
endmodule : brt_sram_top_tb
